//--- otp_program_verify_port.sv
// OTP code memory program/verify port with AXI4-Lite status access
//
// Contract
// - Once key table written, verify returns only encrypted data.
// - Any security bit set blocks code and key writes, not security writes.
// - With security bits 2 and 3 clear, verify drives addressed byte on port 0.
// - Encrypted verify output is stored byte XNOR one of 64 key bytes.
// - No path exists to read key table contents.
// - Signature bytes read at 030h and 031h with port 3 bits 6,7 low.
// - Security bit 1 blocks external table reads; access pin latched once, when the init sweep ends after reset.
// - Security bit 2 also disables verify entirely.
// - All three bits also forbid any external program execution.
// - Key array reads all ones before programming.
// - Verify data valid within 48 oscillator periods of address.
// - Port 0 released within 48 oscillator periods after enable removed.
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module otp_program_verify_port
   import otp_pkg::*;
#(
   parameter int         ADDR_W    = 14,
   parameter logic [7:0] SIG_MAKER = 8'h5A,  // Arbitrary identity value
   parameter logic [7:0] SIG_PART  = 8'hA5   // Arbitrary identity value
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Programming pins
   input  wire otp_pins_s   pins,
   output var  logic [7:0]  p0_out,
   output var  logic [7:0]  p0_oe,
   // Core restrictions
   output var  otp_core_s   core,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output var  logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output var  logic        s_axi_wready,
   output var  logic [1:0]  s_axi_bresp,
   output var  logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output var  logic        s_axi_arready,
   output var  logic [31:0] s_axi_rdata,
   output var  logic [1:0]  s_axi_rresp,
   output var  logic        s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   localparam int DEPTH = 1 << ADDR_W;
   localparam int verify_lim_c = VERIFY_CYC;

   if (ADDR_W < KEY_AW || ADDR_W > 14) begin : g_bad_aw
      $error("ADDR_W must lie between 6 and 14");
   end

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   otp_pins_s ps;

   otp_sync #(.W($bits(otp_pins_s))) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (pins),
      .q       (ps)
   );

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0]          mem_r [DEPTH];
   logic [7:0]          key_r [KEY_DEPTH];
   otp_state_e          state_r;
   logic [ADDR_W-1:0]   init_idx_r;
   logic [SEC_BITS-1:0] sec_r;
   logic                key_done_r;
   logic [2:0]          pulse_cnt_r;
   logic [ADDR_W-1:0]   pgm_addr_r;
   logic [7:0]          pgm_data_r;
   logic [2:0]          pgm_sel_r;
   logic                strobe_d_r;
   logic [7:0]          mem_q_r;
   logic [ADDR_W-1:0]   rd_addr_r;
   logic                rd_ok_r;
   logic                ctrl_en_r;
   logic [15:0]         wr_cnt_r;
   logic                ea_seen_r;

   // ----------------------------------------------------------------
   // Pin decode
   // ----------------------------------------------------------------
   wire [2:0]        sel_w      = {ps.p3_hi, ps.p2[6]};
   wire [ADDR_W-1:0] addr_w     = ADDR_W'({ps.p2[5:0], ps.p1});
   wire              pin_mode_w = ps.rst_pin && !ps.program_store_strobe_n && ctrl_en_r
                                  && state_r == ST_RUN;
   wire              pgm_sel_w  = sel_w == SEL_PGM_CODE || sel_w == SEL_PGM_KEY
                                  || sel_w == SEL_PGM_SEC1 || sel_w == SEL_PGM_SEC2
                                  || sel_w == SEL_PGM_SEC3;
   wire              pgm_mode_w = pin_mode_w && pgm_sel_w && ps.p2[7]
                                  && ps.ext_access_prog_voltage_pin;
   wire              sig_sel_w  = sel_w == SEL_SIG;
   wire              sec_lock_w = |sec_r;
   wire              ver_active = pin_mode_w && (sel_w == SEL_VERIFY || sig_sel_w)
                                  && !ps.p2[7] && !sec_r[1] && !sec_r[2];
   wire              fall_w     = strobe_d_r && !ps.latch_program_strobe;
   wire              rise_w     = !strobe_d_r && ps.latch_program_strobe;
   wire              held_w     = addr_w == pgm_addr_r && ps.p0 == pgm_data_r
                                  && sel_w == pgm_sel_r;
   wire              commit_w   = pgm_mode_w && rise_w && held_w
                                  && pulse_cnt_r == 3'(PULSES);
   wire              wr_code_w  = commit_w && pgm_sel_r == SEL_PGM_CODE && !sec_lock_w;
   wire              wr_key_w   = commit_w && pgm_sel_r == SEL_PGM_KEY && !sec_lock_w;
   wire [KEY_AW-1:0] key_idx_w  = KEY_AW'(rd_addr_r);
   wire [7:0]        key_sel_w  = key_r[key_idx_w];
   wire [7:0]        sig_byte_w = rd_addr_r == SIG_ADDR0[ADDR_W-1:0] ? SIG_MAKER
                                : rd_addr_r == SIG_ADDR1[ADDR_W-1:0] ? SIG_PART : BLANK_BYTE;
   // Key bytes only ever feed the XNOR, never port 0 directly
   wire [7:0]        code_out_w = mem_q_r ~^ key_sel_w;
   wire [7:0]        out_byte_w = sig_sel_w ? sig_byte_w : code_out_w;
   wire              rd_fresh_w = rd_addr_r == addr_w;

   // ----------------------------------------------------------------
   // Init sweep and programming sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r     <= ST_INIT;
         init_idx_r  <= '0;
         pulse_cnt_r <= '0;
         pgm_addr_r  <= '0;
         pgm_data_r  <= '0;
         pgm_sel_r   <= '0;
         strobe_d_r  <= 1'b1;
         wr_cnt_r    <= '0;
      end else begin
         strobe_d_r <= ps.latch_program_strobe;
         if (state_r == ST_INIT) begin
            init_idx_r <= init_idx_r + 1'b1;
            if (init_idx_r == ADDR_W'(DEPTH - 1)) begin
               state_r <= ST_RUN;
            end
         end
         if (!pgm_mode_w) begin
            pulse_cnt_r <= '0;
         end else if (fall_w) begin
            if (pulse_cnt_r == '0 || !held_w) begin
               pulse_cnt_r <= 3'h1;
               pgm_addr_r  <= addr_w;
               pgm_data_r  <= ps.p0;
               pgm_sel_r   <= sel_w;
            end else if (pulse_cnt_r < 3'(PULSES)) begin
               pulse_cnt_r <= pulse_cnt_r + 3'h1;
            end
         end else if (commit_w) begin
            pulse_cnt_r <= '0;
            wr_cnt_r    <= wr_cnt_r + 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Code array: blank fill, then bits only clear
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (state_r == ST_INIT) begin
         mem_r[init_idx_r] <= BLANK_BYTE;
      end else if (wr_code_w) begin
         mem_r[pgm_addr_r] <= mem_r[pgm_addr_r] & pgm_data_r;
      end
      mem_q_r <= mem_r[addr_w];
   end

   // ----------------------------------------------------------------
   // Key array and security bits
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < KEY_DEPTH; i++) begin
            key_r[i] <= BLANK_BYTE;
         end
         key_done_r <= 1'b0;
         sec_r      <= '0;
      end else begin
         if (wr_key_w) begin
            key_r[KEY_AW'(pgm_addr_r)] <= key_r[KEY_AW'(pgm_addr_r)] & pgm_data_r;
            key_done_r                 <= 1'b1;
         end
         if (commit_w && pgm_sel_r == SEL_PGM_SEC1) begin
            sec_r[0] <= 1'b1;
         end
         if (commit_w && pgm_sel_r == SEL_PGM_SEC2) begin
            sec_r[1] <= 1'b1;
         end
         if (commit_w && pgm_sel_r == SEL_PGM_SEC3) begin
            sec_r[2] <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Verify output, open-drain low only
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_addr_r <= '0;
         rd_ok_r   <= 1'b0;
         p0_out    <= '0;
         p0_oe     <= '0;
      end else begin
         rd_addr_r <= addr_w;
         rd_ok_r   <= ver_active && rd_fresh_w;
         p0_out    <= '0;
         p0_oe     <= (ver_active && rd_fresh_w) ? ~out_byte_w : 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Core restrictions and access-pin latch
   // ----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core      <= '0;
         ea_seen_r <= 1'b0;
      end else begin
         core.code_table_read_instr_ext_block <= sec_r[0];
         core.ext_exec_block <= &sec_r;
         if (!ea_seen_r && state_r == ST_RUN) begin
            core.external_access_select <= ps.ext_access_prog_voltage_pin;
            ea_seen_r                   <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   wire aw_go_w = s_axi_awready && s_axi_awvalid;
   wire ar_go_w = s_axi_arready && s_axi_arvalid;
   wire [31:0] status_w = {16'h0000, wr_cnt_r[7:0], 2'b00, ver_active,
                           state_r == ST_INIT, key_done_r, sec_r};
   wire [31:0] rd_mux_w = s_axi_araddr == REG_CTRL   ? {31'h0, ctrl_en_r}
                        : s_axi_araddr == REG_STATUS ? status_w
                        : {16'h0000, wr_cnt_r};
   wire rd_map_w = s_axi_araddr == REG_CTRL || s_axi_araddr == REG_STATUS
                   || s_axi_araddr == REG_WRCNT;
   wire wr_map_w = s_axi_awaddr == REG_CTRL || s_axi_awaddr == REG_STATUS
                   || s_axi_awaddr == REG_WRCNT;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         ctrl_en_r     <= 1'b1;
      end else begin
         s_axi_awready <= !s_axi_awready && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
         s_axi_wready  <= !s_axi_awready && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
         if (aw_go_w) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map_w ? RESP_OKAY : RESP_SLVERR;
            if (s_axi_awaddr == REG_CTRL && s_axi_wstrb[0]) begin
               ctrl_en_r <= s_axi_wdata[CTRL_EN_BIT];
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && s_axi_arvalid && !s_axi_rvalid;
         if (ar_go_w) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_map_w ? rd_mux_w : 32'h0000_0000;
            s_axi_rresp  <= rd_map_w ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   key_lock_a: assert property (sec_lock_w && commit_w
         |=> $stable(key_r[KEY_AW'(pgm_addr_r)]))
      else $error("key table written while locked");
   key_mark_a: assert property (wr_key_w |=> key_done_r)
      else $error("key table write not recorded");
   blank_key_a: assert property (!key_done_r |-> key_sel_w == BLANK_BYTE)
      else $error("unprogrammed key byte not all ones");
   verify_off_a: assert property ((sec_r[1] || sec_r[2]) |=> p0_oe == 8'h00)
      else $error("port 0 driven with verify disabled");
   verify_data_a: assert property (ver_active && !sig_sel_w && rd_fresh_w
         |=> p0_oe == $past(mem_r[rd_addr_r] ^ key_r[key_idx_w]))
      else $error("verify byte wrong");
   verify_time_a: assert property ($rose(ver_active) |-> ##[1:verify_lim_c] rd_ok_r)
      else $error("verify data late");
   float_time_a: assert property ($fell(ver_active) |=> p0_oe == 8'h00)
      else $error("port 0 not released");
   sig_byte_a: assert property (ver_active && sig_sel_w && rd_fresh_w
         && rd_addr_r == SIG_ADDR0[ADDR_W-1:0] |=> p0_oe == ~SIG_MAKER)
      else $error("signature byte wrong");
   ext_block_a: assert property (&sec_r |=> core.ext_exec_block && core.code_table_read_instr_ext_block)
      else $error("external execution not blocked");
   pulse_count_a: assert property (commit_w |-> $past(pulse_cnt_r) == 3'(PULSES))
      else $error("write committed without five pulses");
   code_lock_a: assert property (sec_lock_w && commit_w |=> $stable(mem_r[pgm_addr_r]))
      else $error("code written while locked");
   sec_open_a: assert property (commit_w && pgm_sel_r == SEL_PGM_SEC3 |=> sec_r[2])
      else $error("security bit write refused");
   sig_part_a: assert property (ver_active && sig_sel_w && rd_fresh_w
         && rd_addr_r == SIG_ADDR1[ADDR_W-1:0] |=> p0_oe == ~SIG_PART)
      else $error("signature part byte wrong");
   ea_hold_a: assert property (ea_seen_r |=> $stable(core.external_access_select))
      else $error("access level not held");

endmodule
`default_nettype wire

//--- otp_pkg.sv
// Constants, pin groups and mode codes shared by the OTP program/verify port
package otp_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ     = 100;
   localparam int OSC_MAX_MHZ = 6;
   localparam int OSC_LIMIT   = 48;
   localparam int VERIFY_NS   = OSC_LIMIT * 1000 / OSC_MAX_MHZ;
   localparam int VERIFY_CYC  = VERIFY_NS * CLK_MHZ / 1000;
   localparam int PULSES      = 5;

   // ----------------------------------------------------------------
   // Memory layout
   // ----------------------------------------------------------------
   localparam int KEY_DEPTH = 64;
   localparam int KEY_AW    = 6;
   localparam int SEC_BITS  = 3;
   localparam logic [7:0] BLANK_BYTE = 8'hFF;
   localparam logic [13:0] SIG_ADDR0 = 14'h0030;
   localparam logic [13:0] SIG_ADDR1 = 14'h0031;

   // ----------------------------------------------------------------
   // Mode select {p3_7, p3_6, p2_6}
   // ----------------------------------------------------------------
   localparam logic [2:0] SEL_PGM_CODE = 3'h7;
   localparam logic [2:0] SEL_VERIFY   = 3'h6;
   localparam logic [2:0] SEL_PGM_KEY  = 3'h5;
   localparam logic [2:0] SEL_PGM_SEC1 = 3'h4;
   localparam logic [2:0] SEL_PGM_SEC2 = 3'h3;
   localparam logic [2:0] SEL_PGM_SEC3 = 3'h2;
   localparam logic [2:0] SEL_SIG      = 3'h0;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_WRCNT  = 8'h08;
   localparam int CTRL_EN_BIT   = 0;
   localparam int ST_SEC_LSB    = 0;
   localparam int ST_KEY_BIT    = 3;
   localparam int ST_BUSY_BIT   = 4;
   localparam int ST_VER_BIT    = 5;
   localparam int ST_CNT_LSB    = 8;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [0:0] {ST_INIT, ST_RUN} otp_state_e;

   // ----------------------------------------------------------------
   // Pin groups
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] p0;
      logic [7:0] p1;
      logic [7:0] p2;
      logic [1:0] p3_hi;
      logic       latch_program_strobe;
      logic       ext_access_prog_voltage_pin;
      logic       rst_pin;
      logic       program_store_strobe_n;
   } otp_pins_s;

   typedef struct packed {
      logic code_table_read_instr_ext_block;
      logic ext_exec_block;
      logic external_access_select;
   } otp_core_s;

endpackage

//--- otp_sync.sv
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module otp_sync #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         aclk,
   input  wire logic         aresetn,
   // Levels
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule
`default_nettype wire

//--- otp_prog_model.sv
// Programmer model that drives the OTP port pins
`timescale 1ns/1ps
`default_nettype none
module otp_prog_model
   import otp_pkg::*;
#(
   parameter int SET_CYC = 16,
   parameter int LOW_CYC = 16
) (
   // Clock
   input  wire logic       aclk,
   // Port 0 from the device
   input  wire logic [7:0] p0_out,
   input  wire logic [7:0] p0_oe,
   // Pins and samples
   output var  otp_pins_s  pins,
   output var  logic       smp_stb,
   output var  logic [7:0] smp_data
);
   otp_pins_s  pin_r;
   logic       drv_en;
   logic [7:0] drv_data;
   logic [7:0] p0_wire;

   // Pull-ups hold port 0 high wherever nobody pulls it low
   assign p0_wire = (p0_oe & p0_out) | (~p0_oe & (drv_en ? drv_data : 8'hFF));

   always_comb begin
      pins    = pin_r;
      pins.p0 = p0_wire;
   end

   initial begin
      pin_r                      = '0;
      pin_r.p2                   = 8'h80;
      pin_r.latch_program_strobe = 1'b1;
      pin_r.rst_pin              = 1'b1;
      pin_r.ext_access_prog_voltage_pin = 1'b1;
      drv_en                     = 1'b0;
      drv_data                   = 8'h00;
      smp_stb                    = 1'b0;
      smp_data                   = 8'h00;
   end

   // ----------------------------------------------------------------
   // Pin sequences
   // ----------------------------------------------------------------
   task automatic set_lines(input logic [2:0] sel, input logic [7:0] a, input logic en);
      pin_r.p1    <= a;
      pin_r.p2    <= {en, sel[0], 6'h00};
      pin_r.p3_hi <= sel[2:1];
   endtask

   task automatic write_byte(input logic [2:0] sel, input logic [7:0] a, input logic [7:0] d);
      set_lines(sel, a, 1'b1);
      drv_en   <= 1'b1;
      drv_data <= d;
      repeat (SET_CYC) @(posedge aclk);
      pin_r.ext_access_prog_voltage_pin <= 1'b1;
      repeat (SET_CYC) @(posedge aclk);
      repeat (PULSES) begin
         pin_r.latch_program_strobe <= 1'b0;
         repeat (LOW_CYC) @(posedge aclk);
         pin_r.latch_program_strobe <= 1'b1;
         repeat (LOW_CYC) @(posedge aclk);
      end
      repeat (SET_CYC) @(posedge aclk);
      pin_r.ext_access_prog_voltage_pin <= 1'b0;
      repeat (SET_CYC) @(posedge aclk);
      drv_en <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic read_byte(input logic [2:0] sel, input logic [7:0] a);
      set_lines(sel, a, 1'b0);
      repeat (VERIFY_CYC) @(posedge aclk);
      smp_stb  <= 1'b1;
      smp_data <= p0_wire;
      @(posedge aclk);
      smp_stb     <= 1'b0;
      pin_r.p2[7] <= 1'b1;
      repeat (VERIFY_CYC) @(posedge aclk);
      smp_stb  <= 1'b1;
      smp_data <= p0_wire;
      @(posedge aclk);
      smp_stb <= 1'b0;
      @(posedge aclk);
   endtask
endmodule
`default_nettype wire

//--- otp_program_verify_port_tb.sv
// Self-checking bench for the OTP program/verify port
`timescale 1ns/1ps
`default_nettype none
module otp_program_verify_port_tb import otp_pkg::*; ();
   localparam int         LIMIT = 80000;
   localparam logic [7:0] SIG_M = 8'h3C; // Arbitrary identity value
   localparam logic [7:0] SIG_P = 8'hC3; // Arbitrary identity value
   logic        aclk, aresetn, smp_stb;
   otp_pins_s   pins;
   otp_core_s   core;
   logic [7:0]  p0_out, p0_oe, smp_data, s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [7:0]  mem [256];
   logic [7:0]  key [64];
   logic [7:0]  addrs [6];
   logic [2:0]  sec;
   logic        key_done;
   logic [15:0] cnt;
   logic [33:0] axi_q [$];
   logic [7:0]  pin_q [$];
   int          bad_count = 0;
   int          checked = 0;
   int          cyc = 0;

   otp_program_verify_port #(.ADDR_W(8), .SIG_MAKER(SIG_M), .SIG_PART(SIG_P)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .pins(pins), .p0_out(p0_out), .p0_oe(p0_oe),
      .core(core), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready)
   );

   otp_prog_model u_prog (
      .aclk(aclk), .p0_out(p0_out), .p0_oe(p0_oe), .pins(pins),
      .smp_stb(smp_stb), .smp_data(smp_data)
   );

   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready) check("read", {s_axi_rresp, s_axi_rdata}, axi_q.pop_front());
      if (smp_stb) check("port0", {26'h0, smp_data}, {26'h0, pin_q.pop_front()});
      cyc++;
      if (cyc == LIMIT) begin
         bad_count++;
         wrap_up();
      end
   end

   // ----------------------------------------------------------------
   // Bus and pin helpers
   // ----------------------------------------------------------------
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw_ok;
      logic w_ok;
      aw_ok = 1'b0;
      w_ok  = 1'b0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (s_axi_awready) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      check("bresp", {32'h0, s_axi_bresp}, {32'h0, r});
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      axi_q.push_back({r, d});
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   function automatic logic [31:0] st_exp(input logic busy);
      return {16'h0, cnt[7:0], 3'b000, busy, key_done, sec};
   endfunction

   task automatic prog(input logic [2:0] sel, input logic [7:0] a, input logic [7:0] d);
      u_prog.write_byte(sel, a, d);
      cnt++;
      if (sel == SEL_PGM_CODE && sec == 3'b000) mem[a] = mem[a] & d;
      if (sel == SEL_PGM_KEY && sec == 3'b000) key[a[5:0]] = key[a[5:0]] & d;
      if (sel == SEL_PGM_KEY && sec == 3'b000) key_done = 1'b1;
      if (sel == SEL_PGM_SEC1) sec[0] = 1'b1;
      if (sel == SEL_PGM_SEC2) sec[1] = 1'b1;
      if (sel == SEL_PGM_SEC3) sec[2] = 1'b1;
   endtask

   task automatic rd_pin(input logic [2:0] sel, input logic [7:0] a, input logic [7:0] e);
      pin_q.push_back(e);
      pin_q.push_back(BLANK_BYTE);
      u_prog.read_byte(sel, a);
   endtask

   task automatic verify(input logic [7:0] a);
      rd_pin(SEL_VERIFY, a, (sec[1] | sec[2]) ? BLANK_BYTE : ~(mem[a] ^ key[a[5:0]]));
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      aresetn = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      {sec, key_done, cnt} = '0;
      foreach (mem[i]) mem[i] = BLANK_BYTE;
      foreach (key[i]) key[i] = BLANK_BYTE;
      void'($urandom(32'h301cbfbf));
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(REG_STATUS, st_exp(1'b1), RESP_OKAY);
      repeat (256 + 8) @(posedge aclk);
      check("ea_latch", {33'h0, core.external_access_select}, 34'h1);
      axi_rd(REG_STATUS, st_exp(1'b0), RESP_OKAY);
      axi_rd(REG_CTRL, 32'h1, RESP_OKAY);
      axi_rd(8'h0C, 32'h0, RESP_SLVERR);
      axi_wr(8'h0C, 32'h0, RESP_SLVERR);
      axi_wr(REG_STATUS, 32'hFF, RESP_OKAY);
      axi_rd(REG_STATUS, st_exp(1'b0), RESP_OKAY);
      $display("register test done");
      foreach (addrs[i]) begin
         addrs[i] = 8'($urandom_range(127));
         prog(SEL_PGM_CODE, addrs[i], 8'($urandom));
      end
      prog(SEL_PGM_CODE, addrs[0], 8'($urandom));
      foreach (addrs[i]) verify(addrs[i]);
      verify(8'hC5);
      rd_pin(SEL_SIG, SIG_ADDR0[7:0], SIG_M);
      rd_pin(SEL_SIG, SIG_ADDR1[7:0], SIG_P);
      rd_pin(SEL_SIG, 8'h32, BLANK_BYTE);
      axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
      u_prog.write_byte(SEL_PGM_CODE, 8'hC5, 8'h00);
      axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
      verify(8'hC5);
      axi_rd(REG_WRCNT, {16'h0, cnt}, RESP_OKAY);
      $display("code test done");
      for (int i = 0; i < 32; i++) prog(SEL_PGM_KEY, 8'(i), 8'($urandom));
      axi_rd(REG_STATUS, st_exp(1'b0), RESP_OKAY);
      foreach (addrs[i]) verify(addrs[i]);
      rd_pin(SEL_PGM_KEY, 8'h03, BLANK_BYTE);
      $display("key test done");
      prog(SEL_PGM_SEC1, 8'h00, 8'h00);
      check("code_table_read_instr_block", {33'h0, core.code_table_read_instr_ext_block}, 34'h1);
      prog(SEL_PGM_CODE, addrs[1], 8'h00);
      prog(SEL_PGM_KEY, addrs[1], 8'h00);
      verify(addrs[1]);
      prog(SEL_PGM_SEC2, 8'h00, 8'h00);
      verify(addrs[2]);
      check("exec_block", {33'h0, core.ext_exec_block}, 34'h0);
      prog(SEL_PGM_SEC3, 8'h00, 8'h00);
      check("exec_block", {33'h0, core.ext_exec_block}, 34'h1);
      check("ea_latch", {33'h0, core.external_access_select}, 34'h1);
      axi_rd(REG_STATUS, st_exp(1'b0), RESP_OKAY);
      axi_rd(REG_WRCNT, {16'h0, cnt}, RESP_OKAY);
      $display("security test done");
      wrap_up();
   end
endmodule
`default_nettype wire
